// ===== hw/ptp_timer_core.v
// Behaviour
// - Three channels share one parameterised structure; timer 0 adds pin sources.
// - Each channel is an 8-bit counter behind a 16-bit prescaler.
// - Counter increments by one only on a prescaler output tick.
// - Counter value readable anytime at registers 12, 14, 16.
// - Channel state readable at registers 13, 15, 17.
// - Mode select bit: 0 is timer, 1 is PWM.
// - PWM mode reloads the counter start value automatically.
// - Output and its complement each enabled by own select bit.
// - Tick, clear, run are internal; timer 0 may take them from pins.
// - Tick is prescaler output; timer 0 may divide an external clock.
// - Prescaler division is set by software per channel.
// - Run control starts and stops counting only in timer mode.
// - Counter clear forces the counter to zero.
// - Edge run mode counts between two external rising edges.
// - Timer output is 50% square wave or one-tick pulse.
`timescale 1ns/1ps
`include "ptp_consts.vh"

module ptp_timer_core #(
  parameter NCH = 3,
  parameter CNT_W = `PTP_CNT_W,
  parameter DIV_W = `PTP_DIV_W
) (
  input wire I_CORE_CLK,
  input wire I_RESET,
  input wire [NCH*DIV_W-1:0] I_DIVIDER_SELECT,
  input wire [NCH*CNT_W-1:0] I_COMPARE,
  input wire [NCH*CNT_W-1:0] I_RELOAD,
  input wire [NCH-1:0] I_TIMER_PWM_SELECT,
  input wire [NCH-1:0] I_PULSE_WAVE_SELECT,
  input wire [NCH-1:0] I_SOFT_CLEAR,
  input wire [NCH-1:0] I_SOFT_RUN,
  input wire [NCH-1:0] I_TRUE_OUTPUT_ENABLE,
  input wire [NCH-1:0] I_COMPLEMENT_OUTPUT_ENABLE,
  input wire I_EXT_CLEAR_SOURCE_SELECT,
  input wire I_EXT_RUN_SOURCE_SELECT,
  input wire I_EXT_TICK_SOURCE,
  input wire I_EXT_RUN_EDGE_MODE,
  input wire I_EXT_RUN_PIN,
  input wire I_EXT_CLEAR_PIN,
  input wire I_EXT_CLOCK_PIN,
  input wire [7:0] I_READ_ADDR,
  output reg [7:0] O_READ_DATA,
  output wire [NCH-1:0] O_CHANNEL_OUT_PIN,
  output wire [NCH-1:0] O_CHANNEL_OUT_PIN_OE,
  output wire [NCH-1:0] O_CHANNEL_OUT_N_PIN,
  output wire [NCH-1:0] O_CHANNEL_OUT_N_PIN_OE
);

  // --------------------------------------------------------------------------
  // Timer 0 external source handling
  // --------------------------------------------------------------------------
  // Pins are synchronous; the far side keeps the clock pin below half
  // the master rate, so a single-sample edge detect never misses one.
  reg ext_clk_d;
  reg ext_run_d;
  reg edge_running;
  wire ext_clk_rise = I_EXT_CLOCK_PIN & ~ext_clk_d;
  wire ext_run_rise = I_EXT_RUN_PIN & ~ext_run_d;

  always @(posedge I_CORE_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      ext_clk_d <= 1'b0;
      ext_run_d <= 1'b0;
      edge_running <= 1'b0;
    end
    else
    begin
      ext_clk_d <= I_EXT_CLOCK_PIN;
      ext_run_d <= I_EXT_RUN_PIN;
      if (ext_run_rise)
        edge_running <= ~edge_running;
    end
  end

  wire ext_run = I_EXT_RUN_EDGE_MODE ? edge_running : I_EXT_RUN_PIN;

  // --------------------------------------------------------------------------
  // Channels
  // --------------------------------------------------------------------------
  wire [NCH-1:0] tick;
  wire [NCH-1:0] clear;
  wire [NCH-1:0] run;
  wire [NCH-1:0] wave;
  wire [NCH*CNT_W-1:0] count;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : gen_ch
      wire src_edge;
      if (g == 0)
      begin : gen_ext
        assign src_edge = I_EXT_TICK_SOURCE ? ext_clk_rise : 1'b1;
        assign clear[g] = I_EXT_CLEAR_SOURCE_SELECT ?
                          I_EXT_CLEAR_PIN : I_SOFT_CLEAR[g];
        assign run[g] = I_EXT_RUN_SOURCE_SELECT ?
                        ext_run : I_SOFT_RUN[g];
      end
      else
      begin : gen_int
        assign src_edge = 1'b1;
        assign clear[g] = I_SOFT_CLEAR[g];
        assign run[g] = I_SOFT_RUN[g];
      end

      ptp_divider #(.DIV_W(DIV_W)) u_div (
        .i_clk(I_CORE_CLK),
        .i_reset(I_RESET),
        .i_src_edge(src_edge),
        .i_divider_select(I_DIVIDER_SELECT[g*DIV_W +: DIV_W]),
        .o_divider_out(tick[g])
      );

      ptp_channel #(.CNT_W(CNT_W)) u_ch (
        .i_clk(I_CORE_CLK),
        .i_reset(I_RESET),
        .i_channel_tick(tick[g]),
        .i_counter_clear(clear[g]),
        .i_count_run(run[g]),
        .i_timer_pwm_select(I_TIMER_PWM_SELECT[g]),
        .i_pulse_wave(I_PULSE_WAVE_SELECT[g]),
        .i_compare(I_COMPARE[g*CNT_W +: CNT_W]),
        .i_reload(I_RELOAD[g*CNT_W +: CNT_W]),
        .o_count(count[g*CNT_W +: CNT_W]),
        .o_channel_wave(wave[g])
      );

      // Pins float while the channel is held cleared or under reset,
      // so idle drivers cannot fight an external pull resistor.
      reg wave_pin;
      reg wave_pin_n;
      reg wave_oe;
      reg wave_n_oe;

      always @(posedge I_CORE_CLK or posedge I_RESET)
      begin
        if (I_RESET)
        begin
          wave_pin <= 1'b0;
          wave_pin_n <= 1'b0;
          wave_oe <= 1'b0;
          wave_n_oe <= 1'b0;
        end
        else
        begin
          wave_pin <= wave[g];
          wave_pin_n <= ~wave[g];
          wave_oe <= I_TRUE_OUTPUT_ENABLE[g] & ~clear[g];
          wave_n_oe <= I_COMPLEMENT_OUTPUT_ENABLE[g] & ~clear[g];
        end
      end

      // Each channel owns its own pin flops, so every output bit has
      // exactly one driver.
      assign O_CHANNEL_OUT_PIN[g] = wave_pin;
      assign O_CHANNEL_OUT_N_PIN[g] = wave_pin_n;
      assign O_CHANNEL_OUT_PIN_OE[g] = wave_oe;
      assign O_CHANNEL_OUT_N_PIN_OE[g] = wave_n_oe;
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Readback
  // --------------------------------------------------------------------------
  function [7:0] state_of;
    input integer ch;
    begin
      state_of = `PTP_RD_ZERO;
      state_of[`PTP_ST_RUN] = run[ch];
      state_of[`PTP_ST_WAVE] = wave[ch];
      state_of[`PTP_ST_MODE] = I_TIMER_PWM_SELECT[ch];
      state_of[`PTP_ST_CLEAR] = clear[ch];
    end
  endfunction

  reg [7:0] next_read_data;

  always @*
  begin
    case (I_READ_ADDR)
      `PTP_REG_CNT0: next_read_data = count[0*CNT_W +: CNT_W];
      `PTP_REG_STS0: next_read_data = state_of(0);
      `PTP_REG_CNT1: next_read_data = count[1*CNT_W +: CNT_W];
      `PTP_REG_STS1: next_read_data = state_of(1);
      `PTP_REG_CNT2: next_read_data = count[2*CNT_W +: CNT_W];
      `PTP_REG_STS2: next_read_data = state_of(2);
      default: next_read_data = `PTP_RD_ZERO;
    endcase
  end

  always @(posedge I_CORE_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      O_READ_DATA <= `PTP_RD_ZERO;
    else
      O_READ_DATA <= next_read_data;
  end

endmodule // ptp_timer_core

// ===== hw/ptp_consts.vh
`ifndef PTP_CONSTS_VH
`define PTP_CONSTS_VH
// ----------------------------------------------------------------------------
// Readback register numbers
// ----------------------------------------------------------------------------
`define PTP_REG_CNT0 8'h0C
`define PTP_REG_STS0 8'h0D
`define PTP_REG_CNT1 8'h0E
`define PTP_REG_STS1 8'h0F
`define PTP_REG_CNT2 8'h10
`define PTP_REG_STS2 8'h11
// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define PTP_CNT_W 8
`define PTP_DIV_W 16
`define PTP_CNT_ZERO 8'h00
`define PTP_CNT_ONE 8'h01
`define PTP_CNT_MAX 8'hFF
`define PTP_DIV_ZERO 16'h0000
`define PTP_DIV_ONE 16'h0001
`define PTP_RD_ZERO 8'h00
// ----------------------------------------------------------------------------
// State readback bit positions
// ----------------------------------------------------------------------------
`define PTP_ST_RUN 0
`define PTP_ST_WAVE 1
`define PTP_ST_MODE 2
`define PTP_ST_CLEAR 3
`endif

// ===== hw/ptp_divider.v
`timescale 1ns/1ps
`include "ptp_consts.vh"

module ptp_divider #(
  parameter DIV_W = `PTP_DIV_W
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_src_edge,
  input wire [DIV_W-1:0] i_divider_select,
  output reg o_divider_out
);

  reg [DIV_W-1:0] count;

  // A select of zero is treated as divide by one.
  always @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      count <= {DIV_W{1'b0}};
      o_divider_out <= 1'b0;
    end
    else
    begin
      o_divider_out <= 1'b0;
      if (i_src_edge)
      begin
        if (count + `PTP_DIV_ONE >= i_divider_select)
        begin
          count <= {DIV_W{1'b0}};
          o_divider_out <= 1'b1;
        end
        else
          count <= count + `PTP_DIV_ONE;
      end
    end
  end

endmodule // ptp_divider

// ===== hw/ptp_channel.v
`timescale 1ns/1ps
`include "ptp_consts.vh"

module ptp_channel #(
  parameter CNT_W = `PTP_CNT_W
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_channel_tick,
  input wire i_counter_clear,
  input wire i_count_run,
  input wire i_timer_pwm_select,
  input wire i_pulse_wave,
  input wire [CNT_W-1:0] i_compare,
  input wire [CNT_W-1:0] i_reload,
  output reg [CNT_W-1:0] o_count,
  output reg o_channel_wave
);

  wire pwm = i_timer_pwm_select;
  // In PWM mode the run control does not gate counting; only the clear
  // stops the counter there.
  wire go = pwm | i_count_run;
  wire hit = (o_count == i_compare);

  always @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_count <= `PTP_CNT_ZERO;
      o_channel_wave <= 1'b0;
    end
    else if (i_counter_clear)
    begin
      o_count <= `PTP_CNT_ZERO;
      o_channel_wave <= 1'b0;
    end
    else if (go && i_channel_tick)
    begin
      if (pwm)
      begin
        if (o_count == `PTP_CNT_MAX)
        begin
          o_count <= i_reload;
          o_channel_wave <= (i_compare > i_reload);
        end
        else
        begin
          o_count <= o_count + `PTP_CNT_ONE;
          if (o_count + `PTP_CNT_ONE >= i_compare &&
              i_compare != `PTP_CNT_MAX)
            o_channel_wave <= 1'b0;
        end
      end
      else if (hit)
      begin
        o_count <= `PTP_CNT_ZERO;
        o_channel_wave <= i_pulse_wave ? 1'b1 : ~o_channel_wave;
      end
      else
      begin
        o_count <= o_count + `PTP_CNT_ONE;
        if (i_pulse_wave)
          o_channel_wave <= 1'b0;
      end
    end
    else if (!pwm && i_pulse_wave && i_channel_tick)
      o_channel_wave <= 1'b0;
  end

endmodule // ptp_channel

// ===== bench/ptp_ext_pins.sv
`timescale 1ns/1ps
module ptp_ext_pins (
  input wire i_clk,
  input wire i_go,
  input wire i_run,
  input wire i_clear,
  output reg o_run_pin = 1'b0,
  output reg o_clear_pin = 1'b0,
  output reg o_clock_pin = 1'b0
);
  reg [1:0] ph = 2'h0;
  // The pin clock runs at a quarter of the core rate and rests low when
  // idle, so the core never sees edges closer than its sampler allows.
  always @(posedge i_clk)
  begin
    ph <= ph + 2'h1;
    o_run_pin <= #1 i_run;
    o_clear_pin <= #1 i_clear;
    o_clock_pin <= #1 i_go & ph[1];
  end
endmodule // ptp_ext_pins

// ===== bench/ptp_timer_core_assertions.sv
`timescale 1ns/1ps
module ptp_timer_core_chk #(
  parameter NCH = 3,
  parameter CNT_W = 8,
  parameter DIV_W = 16
) (
  input wire I_CORE_CLK,
  input wire I_RESET,
  input wire [NCH*DIV_W-1:0] I_DIVIDER_SELECT,
  input wire [NCH*CNT_W-1:0] I_COMPARE,
  input wire [NCH-1:0] I_TIMER_PWM_SELECT,
  input wire [NCH-1:0] I_SOFT_CLEAR,
  input wire [NCH-1:0] I_SOFT_RUN,
  input wire [NCH-1:0] I_TRUE_OUTPUT_ENABLE,
  input wire [7:0] I_READ_ADDR,
  input wire [7:0] O_READ_DATA,
  input wire [NCH-1:0] O_CHANNEL_OUT_PIN,
  input wire [NCH-1:0] O_CHANNEL_OUT_PIN_OE,
  input wire [NCH-1:0] O_CHANNEL_OUT_N_PIN,
  input wire [NCH-1:0] O_CHANNEL_OUT_N_PIN_OE
);
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RESET);
  wire idle1 = !I_SOFT_CLEAR[1] && !I_TIMER_PWM_SELECT[1];
  wire look1 = idle1 && I_READ_ADDR == 8'h0E;
  wire fast1 = I_DIVIDER_SELECT[DIV_W+:DIV_W] < 2
    && I_COMPARE[CNT_W+:CNT_W] == 8'hFF;
  idle_reset_a: assert property (
    $fell(I_RESET) |-> O_READ_DATA == 8'h00 && !(|O_CHANNEL_OUT_PIN_OE))
    else $error("outputs not idle after reset");
  unmapped_zero_a: assert property (
    (I_READ_ADDR < 8'h0C || I_READ_ADDR > 8'h11) |=> O_READ_DATA == 8'h00)
    else $error("unmapped read not zero");
  clear_zero_a: assert property (
    (I_SOFT_CLEAR[2] && I_READ_ADDR == 8'h10)[*3] |=> O_READ_DATA == 8'h00)
    else $error("cleared count not zero");
  stop_hold_a: assert property (
    (look1 && !I_SOFT_RUN[1])[*4] |=> $stable(O_READ_DATA))
    else $error("stopped count moved");
  count_step_a: assert property (
    (look1 && I_SOFT_RUN[1] && fast1)[*4]
    |=> O_READ_DATA == $past(O_READ_DATA) + 8'h01)
    else $error("count did not step by one");
  oe_clear_a: assert property (
    I_SOFT_CLEAR[2][*2] |=> !O_CHANNEL_OUT_PIN_OE[2]
    && !O_CHANNEL_OUT_N_PIN_OE[2])
    else $error("pin enabled while cleared");
  oe_enable_a: assert property (
    (!I_SOFT_CLEAR[2] && I_TRUE_OUTPUT_ENABLE[2])[*3]
    |=> O_CHANNEL_OUT_PIN_OE[2])
    else $error("pin enable missing");
  pin_complement_a: assert property (
    O_CHANNEL_OUT_PIN_OE[2] && O_CHANNEL_OUT_N_PIN_OE[2]
    |-> O_CHANNEL_OUT_N_PIN[2] != O_CHANNEL_OUT_PIN[2])
    else $error("complement pin equals true pin");
  cover property ($rose(I_TIMER_PWM_SELECT[2]));
  cover property (I_SOFT_CLEAR[2][*3]);
  cover property ($rose(O_CHANNEL_OUT_PIN[2]));
endmodule // ptp_timer_core_chk
bind ptp_timer_core ptp_timer_core_chk #(
  .NCH(NCH),
  .CNT_W(CNT_W),
  .DIV_W(DIV_W)
) chk (
  .I_CORE_CLK, .I_RESET, .I_DIVIDER_SELECT, .I_COMPARE,
  .I_TIMER_PWM_SELECT, .I_SOFT_CLEAR, .I_SOFT_RUN,
  .I_TRUE_OUTPUT_ENABLE, .I_READ_ADDR, .O_READ_DATA,
  .O_CHANNEL_OUT_PIN, .O_CHANNEL_OUT_PIN_OE,
  .O_CHANNEL_OUT_N_PIN, .O_CHANNEL_OUT_N_PIN_OE
);

// ===== bench/ptp_timer_core_tb.sv
`timescale 1ns/1ps
module ptp_timer_core_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [47:0] dsel = 48'h0;
  reg [23:0] cmp = 24'hFFFFFF;
  reg [23:0] rld = 24'h0;
  reg [2:0] pwm = 3'h0, pws = 3'h0, clr = 3'h0, run = 3'h7;
  reg [2:0] ten = 3'h7, cen = 3'h7;
  reg ecs = 1'b0, ers = 1'b0, ets = 1'b0, erm = 1'b0;
  reg go = 1'b0, prun = 1'b0, pclr = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [7:0] b, ch, n, e, h;
  reg [15:0] dv;
  reg [39:0] rows [0:3];
  wire [7:0] rd;
  wire [2:0] pin, poe, npin, noe;
  wire xrun, xclr, xclk;
  integer fail_count = 0;
  integer checks = 0;
  integer i;
  ptp_ext_pins pe (.i_clk(clk), .i_go(go), .i_run(prun), .i_clear(pclr),
    .o_run_pin(xrun), .o_clear_pin(xclr), .o_clock_pin(xclk));
  ptp_timer_core dut (
    .I_CORE_CLK(clk), .I_RESET(rst), .I_DIVIDER_SELECT(dsel),
    .I_COMPARE(cmp), .I_RELOAD(rld), .I_TIMER_PWM_SELECT(pwm),
    .I_PULSE_WAVE_SELECT(pws), .I_SOFT_CLEAR(clr), .I_SOFT_RUN(run),
    .I_TRUE_OUTPUT_ENABLE(ten), .I_COMPLEMENT_OUTPUT_ENABLE(cen),
    .I_EXT_CLEAR_SOURCE_SELECT(ecs), .I_EXT_RUN_SOURCE_SELECT(ers),
    .I_EXT_TICK_SOURCE(ets), .I_EXT_RUN_EDGE_MODE(erm),
    .I_EXT_RUN_PIN(xrun), .I_EXT_CLEAR_PIN(xclr), .I_EXT_CLOCK_PIN(xclk),
    .I_READ_ADDR(addr), .O_READ_DATA(rd), .O_CHANNEL_OUT_PIN(pin),
    .O_CHANNEL_OUT_PIN_OE(poe), .O_CHANNEL_OUT_N_PIN(npin),
    .O_CHANNEL_OUT_N_PIN_OE(noe));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task close_out;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input [7:0] x, input [7:0] g);
    checks = checks + 1;
    if (g !== x)
    begin
      fail_count = fail_count + 1;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task fin(input string nm);
    $display("done %s", nm);
  endtask
  // Inputs move 1 ns after the edge so the core never races the bench.
  task step(input integer k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task rst_pulse;
    rst = 1'b1;
    step(4);
    chk("reset data", 8'h00, rd);
    chk("reset oe", 8'h00, {2'h0, poe, noe});
    rst = 1'b0;
    step(1);
  endtask
  // The read path is registered, so a difference of two reads taken k
  // cycles apart counts exactly the ticks in between.
  task delta(input [7:0] ad, input [7:0] k, output [7:0] d);
    reg [7:0] s;
    addr = ad;
    step(2);
    s = rd;
    step(k);
    d = rd - s;
  endtask
  initial
  begin
    rows[0] = {8'h00, 16'h0001, 8'h05, 8'h05};
    rows[1] = {8'h01, 16'h0000, 8'h03, 8'h03};
    rows[2] = {8'h02, 16'h0004, 8'h08, 8'h02};
    rows[3] = {8'h00, 16'h0003, 8'h09, 8'h03};
    for (i = 0; i < 4; i = i + 1)
    begin
      {ch, dv, n, e} = rows[i];
      rst_pulse;
      dsel[16*ch+:16] = dv;
      delta(8'h0C + ch * 8'h02, n, b);
      chk("count", e, b);
      fin("row");
    end
    addr = 8'h12;
    step(2);
    chk("unmapped", 8'h00, rd);
    run[1] = 1'b0;
    delta(8'h0E, 8'h06, b);
    chk("stopped", 8'h00, b);
    pwm[1] = 1'b1;
    delta(8'h0E, 8'h04, b);
    chk("pwm free run", 8'h04, b);
    addr = 8'h0F;
    step(2);
    chk("mode bit", 8'h04, rd & 8'h04);
    fin("run");
    clr[2] = 1'b1;
    addr = 8'h10;
    step(4);
    chk("cleared", 8'h00, rd);
    addr = 8'h11;
    step(2);
    chk("clear bit", 8'h08, rd & 8'h08);
    chk("oe off", 8'h00, {6'h0, poe[2], noe[2]});
    clr[2] = 1'b0;
    fin("clear");
    pwm[2] = 1'b1;
    rld[23:16] = 8'hF0;
    cmp[23:16] = 8'hF8;
    dsel[47:32] = 16'h0001;
    addr = 8'h10;
    step(300);
    b = 8'hFF;
    h = 8'h00;
    // Two whole periods of sixteen ticks, half of each below the duty point.
    repeat (32)
    begin
      step(1);
      if (rd < b)
        b = rd;
      h = h + {7'h0, pin[2]};
      chk("complement", {7'h0, ~pin[2]}, {7'h0, npin[2]});
    end
    chk("reload floor", 8'hF0, b);
    chk("pwm duty", 8'h10, h);
    chk("oe on", 8'h03, {6'h0, poe[2], noe[2]});
    fin("pwm");
    pwm[1] = 1'b0;
    run[1] = 1'b1;
    cmp[15:8] = 8'h03;
    for (i = 0; i < 2; i = i + 1)
    begin
      pws[1] = i[0];
      clr[1] = 1'b1;
      step(2);
      clr[1] = 1'b0;
      step(8);
      h = 8'h00;
      repeat (8)
      begin
        step(1);
        h = h + {7'h0, pin[1]};
      end
      chk("timer wave", (i == 0) ? 8'h04 : 8'h02, h);
    end
    fin("wave");
    rst_pulse;
    dsel[15:0] = 16'h0001;
    ets = 1'b1;
    go = 1'b1;
    prun = 1'b1;
    step(4);
    delta(8'h0C, 8'h10, b);
    chk("pin clock", 8'h04, b);
    ers = 1'b1;
    prun = 1'b0;
    step(4);
    delta(8'h0C, 8'h10, b);
    chk("pin stop", 8'h00, b);
    ecs = 1'b1;
    pclr = 1'b1;
    step(6);
    chk("pin clear", 8'h00, rd);
    fin("pins");
    pclr = 1'b0;
    ets = 1'b0;
    erm = 1'b1;
    rst_pulse;
    step(4);
    chk("edge idle", 8'h00, rd);
    prun = 1'b1;
    step(1);
    prun = 1'b0;
    step(8);
    prun = 1'b1;
    step(1);
    prun = 1'b0;
    step(6);
    chk("edge period", 8'h09, rd);
    fin("edge");
    close_out;
  end
  initial
  begin
    #20000;
    fail_count = fail_count + 1;
    close_out;
  end
endmodule // ptp_timer_core_tb
